// ==== scc_top.sv ====
// scc_top: command decoding and registers of the serial interface controller
// assumes: one ahb-lite master, word accesses, a free link clock for shifting
//
// Summary of operation
// RQ1 - the command register at 0x00 is write-only and a zero bit does nothing.
// RQ2 - a one in bit 24 releases the active select once the waiting character has shifted.
// RQ3 - with select hold set, that command raises the held select when that character is out.
// RQ4 - a one in bit 8 empties the receive queue only in queue mode with an overrun seen.
// RQ5 - a one in bit 7 returns the whole interface logic to its reset state; the code keeps the link side and handshake, so a started character finishes.
// RQ6 - after a software reset the interface is in slave mode.
// RQ7 - a software reset leaves the dma channels as they were; the code drops both dma requests, as the reset clears ena and rx_full.
// RQ8 - a one in bit 1 turns all pins to inputs and stops transmit and receive.
// RQ9 - a transfer under way when disable comes is finished first.
// RQ10 - enable and disable in one write leave the interface disabled.
// RQ11 - a one in bit 0 enables the interface for transfer.
// RQ12 - command bits are one-cycle strobes with no storage and read back as zero.
`timescale 1ns/1ns
module scc_top
   import scc_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             link_clk_in,
   input  wire logic             hsel_in,
   input  wire logic [31:0]      haddr_in,
   input  wire logic [1:0]       htrans_in,
   input  wire logic             hwrite_in,
   input  wire logic [2:0]       hsize_in,
   input  wire logic [31:0]      hwdata_in,
   input  wire logic             hready_in,
   output logic      [31:0]      hrdata_out,
   output logic                  hreadyout_out,
   output logic                  hresp_out,
   input  wire logic             miso_in,
   output logic                  sck_out,
   output logic                  mosi_out,
   output logic      [SEL_N-1:0] sel_n_out,
   output logic                  pins_oe_out,
   output logic                  tx_dma_req_out,
   output logic                  rx_dma_req_out
);

   // ---------------------------------------------------------------
   // state and wiring
   // ---------------------------------------------------------------
   scc_bus_st_t q;
   scc_bus_st_t d;
   scc_xfer_if  xfer ();
   logic        ack_s;
   logic        link_idle;
   logic        addr_ok;
   logic        rd_take;
   logic        wr_take;
   logic        cmd_wr;
   logic        mode_wr;
   logic        txd_wr;
   logic        en_cmd;
   logic        dis_cmd;
   logic        reset_cmd;
   logic        flush_cmd;
   logic        last_cmd;
   logic        ack_new;
   logic [31:0] rd_mux;

   // ---------------------------------------------------------------
   // link side and crossing
   // ---------------------------------------------------------------
   scc_sync #(.W(1)) u_ack_sync (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   (xfer.ack_t),
      .sync_out   (ack_s)
   );

   scc_link u_link (
      .link_clk_in (link_clk_in),
      .reset_n_in  (reset_n_in),
      .xfer        (xfer.lnk),
      .miso_in     (miso_in),
      .sck_out     (sck_out),
      .mosi_out    (mosi_out),
      .sel_n_out   (sel_n_out),
      .pins_oe_out (pins_oe_out)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign addr_ok = hsel_in && htrans_in[1] && hready_in;
   assign rd_take = addr_ok && !hwrite_in;
   assign wr_take = addr_ok && hwrite_in && (hsize_in == HSIZE_WORD);

   assign cmd_wr  = q.wr_pend && (q.wr_addr == OFF_CMD);
   assign mode_wr = q.wr_pend && (q.wr_addr == OFF_MODE);
   assign txd_wr  = q.wr_pend && (q.wr_addr == OFF_TXD);

   // RQ12 strobes only
   assign en_cmd    = cmd_wr && hwdata_in[CMD_EN_BIT];
   assign dis_cmd   = cmd_wr && hwdata_in[CMD_DIS_BIT];
   assign reset_cmd = cmd_wr && hwdata_in[CMD_SOFT_BIT];
   assign flush_cmd = cmd_wr && hwdata_in[CMD_FLUSH_BIT];
   assign last_cmd  = cmd_wr && hwdata_in[CMD_LAST_BIT];

   assign link_idle = (q.req_t == ack_s);
   assign ack_new   = (ack_s != q.ack_seen);

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_mux = '0;
      case (haddr_in[7:0])
         OFF_MODE:
         begin
            rd_mux[MODE_MASTER_BIT]                   = q.master;
            rd_mux[MODE_QUEUE_BIT]                    = q.qmode;
            rd_mux[MODE_SEL_LSB +: SEL_W]             = q.sel;
            rd_mux[MODE_HOLD_LSB +: SEL_N]            = q.hold;
         end
         OFF_TXD:
            rd_mux[CHAR_W-1:0] = q.tx_char;
         OFF_RXD:
            rd_mux[CHAR_W-1:0] = q.rx;
         OFF_STAT:
         begin
            rd_mux[ST_ENA_BIT]  = q.ena;
            rd_mux[ST_BUSY_BIT] = !link_idle;
            rd_mux[ST_TDE_BIT]  = !q.tx_full;
            rd_mux[ST_RXF_BIT]  = q.rx_full;
            rd_mux[ST_OVR_BIT]  = q.ovr;
            rd_mux[ST_REL_BIT]  = q.rel_pend;
            rd_mux[ST_MST_BIT]  = q.master;
         end
         // RQ1 command reads zero
         OFF_CMD:
            rd_mux = '0;
         default:
            rd_mux = '0;
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;

      // address phase
      d.wr_pend = wr_take;
      d.wr_addr = haddr_in[7:0];
      if (rd_take)
         d.rdata = rd_mux;

      // read side effects
      if (rd_take && (haddr_in[7:0] == OFF_RXD))
         d.rx_full = 1'b0;
      if (rd_take && (haddr_in[7:0] == OFF_STAT))
         d.ovr = 1'b0;

      // RQ4 flush only in queue mode after overrun
      if (flush_cmd && q.qmode && q.ovr)
      begin
         d.rx_full = 1'b0;
         d.ovr     = 1'b0;
      end

      // finished character from the link, set beats a read or flush clear
      if (ack_new)
      begin
         d.ack_seen = ack_s;
         if (q.req.shift)
         begin
            if (d.rx_full)
               d.ovr = 1'b1;
            d.rx      = xfer.rx_data;
            d.rx_full = 1'b1;
         end
      end

      // mode register
      if (mode_wr)
      begin
         d.master = hwdata_in[MODE_MASTER_BIT];
         d.qmode  = hwdata_in[MODE_QUEUE_BIT];
         d.sel    = hwdata_in[MODE_SEL_LSB +: SEL_W];
         d.hold   = hwdata_in[MODE_HOLD_LSB +: SEL_N];
      end

      // transmit data, refused while full or not running
      if (txd_wr && q.ena && q.master && !q.tx_full)
      begin
         d.tx_char = hwdata_in[CHAR_W-1:0];
         d.tx_full = 1'b1;
      end

      // RQ11 enable
      if (en_cmd)
         d.ena = 1'b1;

      // RQ8 disable stops new traffic
      // RQ10 disable wins over enable
      if (dis_cmd)
      begin
         d.ena      = 1'b0;
         d.tx_full  = 1'b0;
      end

      // RQ2 release request
      if (last_cmd)
         d.rel_pend = 1'b1;

      // launch toward the link
      if (link_idle)
      begin
         if (d.tx_full && d.ena && d.master)
         begin
            d.req.data  = d.tx_char;
            d.req.sel   = d.sel;
            d.req.hold  = d.hold[d.sel];
            d.req.last  = d.rel_pend;
            d.req.shift = 1'b1;
            d.req_t     = ~q.req_t;
            d.tx_full   = 1'b0;
            d.rel_pend  = 1'b0;
         end
         // RQ3 release held select
         else if (d.rel_pend)
         begin
            d.req.sel   = d.sel;
            d.req.hold  = d.hold[d.sel];
            d.req.last  = 1'b1;
            d.req.shift = 1'b0;
            d.req_t     = ~q.req_t;
            d.rel_pend  = 1'b0;
         end
      end

      // RQ5 software reset of the interface
      // RQ6 slave mode afterwards
      if (reset_cmd)
      begin
         d.ena      = BUS_ST_RST.ena;
         d.master   = BUS_ST_RST.master;
         d.qmode    = BUS_ST_RST.qmode;
         d.sel      = BUS_ST_RST.sel;
         d.hold     = BUS_ST_RST.hold;
         d.tx_char  = BUS_ST_RST.tx_char;
         d.tx_full  = BUS_ST_RST.tx_full;
         d.rx       = BUS_ST_RST.rx;
         d.rx_full  = BUS_ST_RST.rx_full;
         d.ovr      = BUS_ST_RST.ovr;
         d.rel_pend = BUS_ST_RST.rel_pend;
         // handshake kept so an in-flight character closes cleanly
         d.req_t    = d.req_t;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         q <= BUS_ST_RST;
      else
         q <= d;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign xfer.req_t   = q.req_t;
   assign xfer.req     = q.req;
   assign xfer.pins_on = q.ena & q.master;

   assign hrdata_out    = q.rdata;
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   // RQ7 dma requests follow data state, tx also gated by enable and master
   assign tx_dma_req_out = q.ena && q.master && !q.tx_full;
   assign rx_dma_req_out = q.rx_full;

endmodule : scc_top

// ==== scc_pkg.sv ====
// scc_pkg: constants and state types of the serial interface command block
// assumes: 32-bit ahb-lite register port, one 8-bit character per transfer
package scc_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CMD   = 8'h00;
   localparam logic [7:0] OFF_MODE  = 8'h04;
   localparam logic [7:0] OFF_TXD   = 8'h08;
   localparam logic [7:0] OFF_RXD   = 8'h0C;
   localparam logic [7:0] OFF_STAT  = 8'h10;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CMD_EN_BIT      = 0;
   localparam int CMD_DIS_BIT     = 1;
   localparam int CMD_SOFT_BIT    = 7;
   localparam int CMD_FLUSH_BIT   = 8;
   localparam int CMD_LAST_BIT    = 24;
   localparam int MODE_MASTER_BIT = 0;
   localparam int MODE_QUEUE_BIT  = 1;
   localparam int MODE_SEL_LSB    = 4;
   localparam int MODE_HOLD_LSB   = 8;
   localparam int ST_ENA_BIT      = 0;
   localparam int ST_BUSY_BIT     = 1;
   localparam int ST_TDE_BIT      = 2;
   localparam int ST_RXF_BIT      = 3;
   localparam int ST_OVR_BIT      = 4;
   localparam int ST_REL_BIT      = 5;
   localparam int ST_MST_BIT      = 6;

   // ---------------------------------------------------------------
   // widths and counts
   // ---------------------------------------------------------------
   localparam int CHAR_W = 8;
   localparam int SEL_N  = 4;
   localparam int SEL_W  = 2;
   localparam logic [3:0] STEP_LAST = 4'(2 * CHAR_W - 1);
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ---------------------------------------------------------------
   // state types and reset values
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CHAR_W-1:0] data;
      logic [SEL_W-1:0]  sel;
      logic              hold;
      logic              last;
      logic              shift;
   } scc_xfer_req_t;

   typedef struct packed {
      logic              wr_pend;
      logic [7:0]        wr_addr;
      logic [31:0]       rdata;
      logic              ena;
      logic              master;
      logic              qmode;
      logic [SEL_W-1:0]  sel;
      logic [SEL_N-1:0]  hold;
      logic [CHAR_W-1:0] tx_char;
      logic              tx_full;
      logic [CHAR_W-1:0] rx;
      logic              rx_full;
      logic              ovr;
      logic              rel_pend;
      logic              req_t;
      scc_xfer_req_t     req;
      logic              ack_seen;
   } scc_bus_st_t;

   typedef struct packed {
      logic              busy;
      logic [3:0]        step;
      logic [CHAR_W-1:0] sh;
      logic [CHAR_W-1:0] rx;
      logic [SEL_N-1:0]  sel;
      logic              sck;
      logic              mosi;
      logic              seen_t;
      logic              ack_t;
   } scc_link_st_t;

   localparam scc_bus_st_t  BUS_ST_RST  = '0;
   localparam scc_link_st_t LINK_ST_RST = '0;

endpackage : scc_pkg

// ==== scc_xfer_if.sv ====
// scc_xfer_if: toggle handshake between bus side and link side
// assumes: payload stands still from req_t toggle until ack_t answers
`timescale 1ns/1ns
interface scc_xfer_if;
   import scc_pkg::*;
   logic              req_t;
   scc_xfer_req_t     req;
   logic              pins_on;
   logic              ack_t;
   logic [CHAR_W-1:0] rx_data;

   modport ctl (output req_t, output req, output pins_on, input ack_t, input rx_data);
   modport lnk (input req_t, input req, input pins_on, output ack_t, output rx_data);
endinterface : scc_xfer_if

// ==== scc_sync.sv ====
// scc_sync: two-flop level synchroniser, W bits wide
// assumes: each bit is a slow level or a toggle
`timescale 1ns/1ns
module scc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         reset_n_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } scc_sync_st_t;

   scc_sync_st_t q;
   scc_sync_st_t d;

   if (W < 1)
   begin : g_bad_width
      $error("scc_sync: width must be at least one");
   end

   always_comb
   begin
      d    = q;
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         q <= '0;
      else
         q <= d;
   end

   assign sync_out = q.s2;
endmodule : scc_sync

// ==== scc_link.sv ====
// scc_link: character shifter on the link clock, drives clock, data, selects
// assumes: link_clk_in runs free; miso_in is timed by the serial clock made here
`timescale 1ns/1ns
module scc_link
   import scc_pkg::*;
(
   input  wire logic             link_clk_in,
   input  wire logic             reset_n_in,
   scc_xfer_if.lnk               xfer,
   input  wire logic             miso_in,
   output logic                  sck_out,
   output logic                  mosi_out,
   output logic      [SEL_N-1:0] sel_n_out,
   output logic                  pins_oe_out
);
   scc_link_st_t q;
   scc_link_st_t d;
   logic [1:0]   sy;

   scc_sync #(.W(2)) u_req_sync (
      .clk_in     (link_clk_in),
      .reset_n_in (reset_n_in),
      .async_in   ({xfer.req_t, xfer.pins_on}),
      .sync_out   (sy)
   );

   always_comb
   begin
      d = q;
      if (!q.busy)
      begin
         d.sck = 1'b0;
         if (q.seen_t != q.ack_t)
         begin
            // clock back low and answer on the same link clock edge
            d.ack_t = ~q.ack_t;
            // RQ2 release after character
            if (xfer.req.last || !xfer.req.hold)
               d.sel = '0;
         end
         else if (sy[1] != q.seen_t)
         begin
            d.seen_t = sy[1];
            if (xfer.req.shift && sy[0])
            begin
               d.busy = 1'b1;
               d.step = '0;
               d.sh   = xfer.req.data;
               d.sel  = SEL_N'(1) << xfer.req.sel;
            end
            else
            begin
               // RQ3 release only request
               d.sel   = '0;
               d.ack_t = ~q.ack_t;
            end
         end
         else if (!sy[0])
            // RQ8 disabled, selects released
            d.sel = '0;
      end
      else
      begin
         if (!q.step[0])
         begin
            d.sck  = 1'b0;
            d.mosi = q.sh[CHAR_W-1];
         end
         else
         begin
            d.sck = 1'b1;
            d.sh  = {q.sh[CHAR_W-2:0], miso_in};
         end
         d.step = q.step + 4'h1;
         // RQ9 character always finishes
         if (q.step == STEP_LAST)
         begin
            d.busy = 1'b0;
            d.rx   = {q.sh[CHAR_W-2:0], miso_in};
         end
      end
   end

   always_ff @(posedge link_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         q <= LINK_ST_RST;
      else
         q <= d;
   end

   assign sck_out      = q.sck;
   assign mosi_out     = q.mosi;
   assign sel_n_out    = ~q.sel;
   assign pins_oe_out  = sy[0] | q.busy | (q.seen_t != q.ack_t);
   assign xfer.ack_t   = q.ack_t;
   assign xfer.rx_data = q.rx;
endmodule : scc_link

// ==== scc_checker.sv ====
// scc_checker: bus-clock assertions on the pins of scc_top
// assumes: bound to scc_top, reset_n_in clears both clock domains
`timescale 1ns/1ns
module scc_checker
   import scc_pkg::*;
(
   input wire logic             clk_in,
   input wire logic             reset_n_in,
   input wire logic             link_clk_in,
   input wire logic             hsel_in,
   input wire logic [31:0]      haddr_in,
   input wire logic [1:0]       htrans_in,
   input wire logic             hwrite_in,
   input wire logic [2:0]       hsize_in,
   input wire logic [31:0]      hwdata_in,
   input wire logic             hready_in,
   input wire logic [31:0]      hrdata_out,
   input wire logic             sck_out,
   input wire logic [SEL_N-1:0] sel_n_out,
   input wire logic             pins_oe_out,
   input wire logic             tx_dma_req_out
);
   // ---------------------------------------------------------------
   // helper logic
   // ---------------------------------------------------------------
   logic       take;
   logic       cmd_wr_q;
   logic       sck_q;
   logic [3:0] edge_cnt_q;

   assign take = hsel_in & htrans_in[1] & hready_in;

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cmd_wr_q   <= 1'b0;
         sck_q      <= 1'b0;
         edge_cnt_q <= 4'h0;
      end
      else
      begin
         cmd_wr_q <= take & hwrite_in & (haddr_in[7:0] == OFF_CMD) & (hsize_in == HSIZE_WORD);
         sck_q    <= sck_out;
         if (&sel_n_out)
            edge_cnt_q <= 4'h0;
         else if (sck_out & !sck_q)
            edge_cnt_q <= edge_cnt_q + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   AST_CMD_READS_ZERO: assert property (
      take & !hwrite_in & (haddr_in[7:0] == OFF_CMD) |=> hrdata_out == 32'h0)
      else $error("command register read back nonzero");
   AST_SOFT_RESET_SLAVE: assert property (
      cmd_wr_q & hwdata_in[CMD_SOFT_BIT] |-> ##2 !tx_dma_req_out)
      else $error("master transmit request after soft reset");
   AST_DISABLE_QUIET: assert property (
      cmd_wr_q & hwdata_in[CMD_DIS_BIT] |-> ##[1:120] !pins_oe_out)
      else $error("pins still driven after disable");
   AST_SCK_NEEDS_OE: assert property (
      sck_out |-> pins_oe_out)
      else $error("serial clock high with pins released");
   AST_SCK_IN_FRAME: assert property (
      sck_out |-> !(&sel_n_out))
      else $error("serial clock with no select low");
   AST_ONE_SELECT: assert property (
      $onehot0(~sel_n_out))
      else $error("more than one select low");
   AST_LAST_RELEASE: assert property (
      cmd_wr_q & hwdata_in[CMD_LAST_BIT] |-> ##[1:300] (&sel_n_out))
      else $error("select not released after last command");
   AST_WHOLE_CHARS: assert property (
      $rose(&sel_n_out) |-> edge_cnt_q[2:0] == 3'h0)
      else $error("select released inside a character");
endmodule : scc_checker

bind scc_top scc_checker u_chk (.clk_in, .reset_n_in, .link_clk_in, .hsel_in, .haddr_in,
   .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .sck_out,
   .sel_n_out, .pins_oe_out, .tx_dma_req_out);

// ==== scc_periph_model.sv ====
// scc_periph_model: serial peripheral on select 0, mode 0, msb first
// assumes: sck idles low; miso is not pulled, so it toggles when released
`timescale 1ns/1ns
module scc_periph_model
(
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   input  wire logic       sel_n_in,
   input  wire logic [7:0] reply_in,
   output logic            miso_out,
   output logic [7:0]      got_out,
   output int              nbits_out
);
   logic [7:0] sh;

   initial
   begin
      miso_out  = 1'b0;
      got_out   = 8'h00;
      nbits_out = 0;
      sh        = 8'h00;
   end

   // sample on rising serial clock
   always @(posedge sck_in)
      if (!sel_n_in)
      begin
         got_out   <= {got_out[6:0], mosi_in};
         nbits_out <= nbits_out + 1;
      end

   // first bit at select fall
   always @(negedge sel_n_in)
   begin
      sh = reply_in;
      miso_out <= reply_in[7];
   end

   // next bit on falling clock, fresh reply every eight bits
   always @(negedge sck_in)
      if (!sel_n_in)
      begin
         if (nbits_out % 8 == 0)
            sh = reply_in;
         else
            sh = {sh[6:0], 1'b0};
         miso_out <= sh[7];
      end

   // released line shows no stale value
   always @(posedge sel_n_in)
      miso_out <= ~miso_out;
endmodule : scc_periph_model

// ==== spi_command_control_tb_top.sv ====
// spi_command_control_tb_top: register-level tests of the command block
// assumes: one peripheral model on select 0 answering 8'h3C every character
`timescale 1ns/1ns
module spi_command_control_tb_top
   import scc_pkg::*;
;
   logic             clk_in;
   logic             reset_n_in;
   logic             link_clk_in;
   logic             hsel_in;
   logic [31:0]      haddr_in;
   logic [1:0]       htrans_in;
   logic             hwrite_in;
   logic [2:0]       hsize_in;
   logic [31:0]      hwdata_in;
   logic [31:0]      hrdata_out;
   logic             hreadyout_out;
   logic             hresp_out;
   logic             miso_in;
   logic             sck_out;
   logic             mosi_out;
   logic [SEL_N-1:0] sel_n_out;
   logic             pins_oe_out;
   logic             tx_dma_req_out;
   logic             rx_dma_req_out;
   logic [7:0]       got;
   logic [31:0]      rd;
   int               nb;
   int               failures = 0;
   int               n_checks = 0;
   int               cycles   = 0;

   scc_top uut (.clk_in, .reset_n_in, .link_clk_in, .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
      .hreadyout_out, .hresp_out, .miso_in, .sck_out, .mosi_out, .sel_n_out,
      .pins_oe_out, .tx_dma_req_out, .rx_dma_req_out);

   scc_periph_model m (.sck_in(sck_out), .mosi_in(mosi_out), .sel_n_in(sel_n_out[0]),
      .reply_in(8'h3C), .miso_out(miso_in), .got_out(got), .nbits_out(nb));

   // ---------------------------------------------------------------
   // clocks, timeout, tasks
   // ---------------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   initial
   begin
      link_clk_in = 1'b0;
      #37;
      forever #80 link_clk_in = ~link_clk_in;
   end

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      n_checks++;
      if (got_v !== exp_v)
      begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, got_v, exp_v);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr_in  <= {24'h0, a};
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      hsel_in   <= 1'b1;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      rd = hrdata_out;
   endtask : bus

   task automatic wait_bits(input int n);
      while (nb < n) @(posedge clk_in);
      repeat (10) @(posedge clk_in);
   endtask : wait_bits

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial
   begin
      reset_n_in = 1'b0;
      hsel_in    = 1'b0;
      haddr_in   = 32'h0;
      htrans_in  = 2'h0;
      hwrite_in  = 1'b0;
      hsize_in   = HSIZE_WORD;
      hwdata_in  = 32'h0;
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      chk(32'(sel_n_out), 32'hF);
      chk(32'(pins_oe_out), 32'h0);
      bus(1'b1, 8'h20, 32'hFFFFFFFF);
      chk(32'(hresp_out), 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, OFF_CMD, 32'h0);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(32'(rd[ST_ENA_BIT]), 32'h0);
      bus(1'b1, OFF_MODE, 32'h101);
      bus(1'b1, OFF_CMD, 32'h1);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(32'(rd[ST_ENA_BIT]), 32'h1);
      bus(1'b0, OFF_CMD, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, OFF_TXD, 32'hA5);
      wait_bits(8);
      chk(32'(got), 32'hA5);
      chk(32'(sel_n_out), 32'hE);
      bus(1'b0, OFF_RXD, 32'h0);
      chk(rd, 32'h3C);
      bus(1'b1, OFF_CMD, 32'h0100_0000);
      repeat (20) @(posedge clk_in);
      chk(32'(sel_n_out), 32'hF);
      bus(1'b1, OFF_MODE, 32'h1);
      bus(1'b1, OFF_TXD, 32'h11);
      wait_bits(16);
      chk(32'(rx_dma_req_out), 32'h1);
      bus(1'b1, OFF_TXD, 32'h22);
      wait_bits(24);
      bus(1'b1, OFF_CMD, 32'h100);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(32'(rd[ST_OVR_BIT:ST_RXF_BIT]), 32'h3);
      bus(1'b1, OFF_TXD, 32'h33);
      wait_bits(32);
      bus(1'b1, OFF_MODE, 32'h3);
      bus(1'b1, OFF_CMD, 32'h100);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(32'(rd[ST_OVR_BIT:ST_RXF_BIT]), 32'h0);
      bus(1'b1, OFF_TXD, 32'h5A);
      while (nb < 34) @(posedge clk_in);
      bus(1'b1, OFF_CMD, 32'h2);
      chk(32'(pins_oe_out), 32'h1);
      wait_bits(40);
      chk(32'(got), 32'h5A);
      chk(32'(pins_oe_out), 32'h0);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(32'(rd[ST_ENA_BIT]), 32'h0);
      bus(1'b1, OFF_TXD, 32'h77);
      repeat (100) @(posedge clk_in);
      chk(32'(nb), 32'd40);
      bus(1'b1, OFF_CMD, 32'h1);
      bus(1'b1, OFF_CMD, 32'h3);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(32'(rd[ST_ENA_BIT]), 32'h0);
      bus(1'b1, OFF_CMD, 32'h1);
      bus(1'b1, OFF_CMD, 32'h80);
      bus(1'b0, OFF_MODE, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(32'(rd[ST_ENA_BIT]), 32'h0);
      results();
   end
endmodule : spi_command_control_tb_top
